// ### trig_seq_pkg.sv
/*
 Shared constants of the trigger sequencer control block: register map,
 field positions, reset values and the command codes it understands.
 Assumes a 16-bit register word and a 125 MHz system clock.
*/
package trig_seq_pkg;
   // Register indices on the plain register port
   localparam logic [2:0] ADDR_CTRL_STATUS = 3'h0;
   localparam logic [2:0] ADDR_STEP_DELAY  = 3'h1;
   localparam logic [2:0] ADDR_LOOP_CNT0   = 3'h2;
   localparam logic [2:0] ADDR_TIMER0      = 3'h3;
   localparam logic [2:0] ADDR_PULSE_WIDTH = 3'h4;
   localparam logic [2:0] ADDR_WDOG_LIMIT  = 3'h5;
   localparam logic [2:0] ADDR_TRIG_LEVEL  = 3'h6;

   // Control/status field positions
   localparam int BIT_ENABLE     = 15;
   localparam int BIT_IDLE_STOP  = 13;
   localparam int BIT_TOGGLE     = 12;
   localparam int BIT_SW_TRIG    = 10;
   localparam int BIT_SSTEP      = 9;
   localparam int BIT_VISIBLE    = 8;
   localparam int BIT_START      = 7;
   localparam int BIT_WDOG_TO    = 6;
   localparam int BIT_WAIT_MODE1 = 1;
   localparam int BIT_WAIT_MODE0 = 0;

   // Writable positions; bits 14, 11 and 5..2 are unimplemented
   localparam logic [15:0] CTRL_WR_MASK = 16'hB783;
   localparam logic [15:0] CTRL_RESET   = 16'h0000;
   localparam logic [15:0] LIMIT_RESET  = 16'h0000;
   localparam logic [15:0] WDOG_RESET   = 16'h0FFF;

   // Command codes, upper nibble of a command word
   localparam logic [3:0] OP_CTRL_STEP  = 4'h0;
   localparam logic [3:0] OP_WAIT_HIGH  = 4'h1;
   localparam logic [3:0] OP_WAIT_LOW   = 4'h2;
   localparam logic [3:0] OP_TRIG_OUT   = 4'h3;
   localparam logic [3:0] OP_STEP_DELAY = 4'h4;
   localparam logic [3:0] OP_TIMER_WAIT = 4'h5;
   localparam logic [3:0] OP_LOOP_JUMP  = 4'h6;

   // Control step option waiting on the software trigger
   localparam logic [3:0] CTRL_OPT_SW_WAIT = 4'hA;

   localparam logic [3:0] CMD_ADDR_RESET = 4'h0;
endpackage

// ### trig_out_cell.sv
/*
 One trigger output cell: toggles or pulses its line on each fire strobe.
 Assumes fire is a one-cycle strobe in the system clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module trig_out_cell #(
   parameter int PW_BITS = 4
) (
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire logic               i_fire,
   input  wire logic               i_toggle_mode,
   input  wire logic [PW_BITS-1:0] i_pulse_width,
   output logic                    o_level
);
   logic [PW_BITS-1:0] remain;
   logic               level;
   logic [PW_BITS-1:0] next_remain;
   logic               next_level;
   wire                pulse_busy = (remain != '0);

   // Pulse width counts in cycles, a width field of 0 still yields one cycle
   always_comb begin
      next_remain = remain;
      next_level  = level;
      if (i_fire && i_toggle_mode) begin
         next_level  = ~level;
         next_remain = '0;
      end else if (i_fire) begin
         next_level  = 1'b1;
         next_remain = i_pulse_width;
      end else if (!i_toggle_mode && pulse_busy) begin
         next_remain = remain - 1'b1;
      end else if (!i_toggle_mode) begin
         next_level = 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         remain <= '0;
         level  <= 1'b0;
      end else begin
         remain <= next_remain;
         level  <= next_level;
      end
   end

   assign o_level = level;
endmodule
`default_nettype wire

// ### trig_seq_ctrl.sv
/*
 Control and status of a trigger sequencer: register file, a small command
 interpreter over a command store, step delay, loop counter, timer,
 watchdog and trigger output cells.
 Assumes synchronous inputs, one 125 MHz clock and a master that never
 waits for the slave.
*/
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - The sequencer runs only while the enable bit is set.
// - With idle stop set, the sequencer halts while the device idles.
// - In toggle mode each trigger command inverts the selected output.
// - Otherwise each trigger command emits one pulse of the programmed width plus one cycle.
// - Writing one to the software trigger bit delivers a trigger event.
// - Writing zero to the software trigger bit does nothing.
// - Only the control step's software-wait option consumes the software trigger.
// - Single-step bit enters single-step mode; clearing it leaves it.
// - With visibility set, step delay, loop and timer limit reads return live counter or timer values.
// - With visibility clear, limit reads return last written limit values.
// - Setting start runs stored commands one after another continuously.
// - Clearing start stops command execution.
// - Hardware sets the watchdog time-out flag on expiry; resets to zero.
// - Wait-mode bits affect only the wait-high and wait-low commands.
// - Unimplemented control bits read zero and ignore writes.
module trig_seq_ctrl #(
   parameter int N_OUT   = 4,
   parameter int N_CMD   = 16,
   parameter int N_IN    = 4
) (
   input  wire logic             I_CLK,
   input  wire logic             I_SYS_RST,
   input  wire logic [2:0]       I_ADDR,
   input  wire logic [15:0]      I_WDATA,
   input  wire logic             I_WR,
   input  wire logic             I_RD,
   input  wire logic             I_CMD_WR,
   input  wire logic [3:0]       I_CMD_ADDR,
   input  wire logic [7:0]       I_CMD_DATA,
   input  wire logic             I_DEVICE_IDLE,
   input  wire logic [N_IN-1:0]  I_TRIG_IN,
   output logic      [15:0]      O_RDATA,
   output logic      [N_OUT-1:0] O_TRIG_OUT,
   output logic                  O_STEP_DONE,
   output logic                  O_BUSY
);
   // Gray codes around the fetch, exec, wait and hold loop
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FETCH = 3'b001,
      ST_EXEC  = 3'b011,
      ST_WAIT  = 3'b111,
      ST_HOLD  = 3'b101
   } seq_state_t;

   logic [7:0]       cmd_mem [N_CMD];
   seq_state_t       state;
   seq_state_t       next_state;
   logic [15:0]      ctrl;
   logic [15:0]      step_delay_limit;
   logic [15:0]      loop_counter_limit;
   logic [15:0]      timer_limit;
   logic [3:0]       pulse_width_field;
   logic [15:0]      wdog_limit;
   logic [15:0]      step_delay_counter;
   logic [15:0]      loop_counter;
   logic [15:0]      timer;
   logic [15:0]      wdog_count;
   logic [3:0]       pc;
   logic [7:0]       cmd;
   logic             sw_trigger;
   logic             step_permit;
   logic [15:0]      rdata;
   logic [N_IN-1:0]  in_prev;

   wire wr_ctrl   = I_WR && (I_ADDR == trig_seq_pkg::ADDR_CTRL_STATUS);
   wire wr_sdl    = I_WR && (I_ADDR == trig_seq_pkg::ADDR_STEP_DELAY);
   wire wr_loop   = I_WR && (I_ADDR == trig_seq_pkg::ADDR_LOOP_CNT0);
   wire wr_tmr    = I_WR && (I_ADDR == trig_seq_pkg::ADDR_TIMER0);
   wire wr_pw     = I_WR && (I_ADDR == trig_seq_pkg::ADDR_PULSE_WIDTH);
   wire wr_wdog   = I_WR && (I_ADDR == trig_seq_pkg::ADDR_WDOG_LIMIT);

   wire enabled   = ctrl[trig_seq_pkg::BIT_ENABLE];
   wire idle_halt = ctrl[trig_seq_pkg::BIT_IDLE_STOP] && I_DEVICE_IDLE;
   wire toggle_md = ctrl[trig_seq_pkg::BIT_TOGGLE];
   wire sstep     = ctrl[trig_seq_pkg::BIT_SSTEP];
   wire visible   = ctrl[trig_seq_pkg::BIT_VISIBLE];
   wire started   = ctrl[trig_seq_pkg::BIT_START];
   wire [1:0] wait_mode = {ctrl[trig_seq_pkg::BIT_WAIT_MODE1],
                           ctrl[trig_seq_pkg::BIT_WAIT_MODE0]};
   // Halting freezes the step delay counter, loop counter, timer and watchdog, not only fetches
   wire running   = enabled && !idle_halt && started;
   // Single step: one command per software trigger, debug use only
   wire may_fetch = running && (!sstep || step_permit);

   wire [3:0] op     = cmd[7:4];
   wire [3:0] opt    = cmd[3:0];
   wire [1:0] in_sel = opt[1:0];
   wire in_now       = I_TRIG_IN[in_sel];
   wire in_was       = in_prev[in_sel];
   // Wait mode: 00/01 level, 10/11 edge; only wait commands look at it
   wire edge_mode    = wait_mode[1];
   wire high_met     = edge_mode ? (in_now && !in_was) : in_now;
   wire low_met      = edge_mode ? (!in_now && in_was) : !in_now;
   wire sw_wait_cmd  = (op == trig_seq_pkg::OP_CTRL_STEP) &&
                       (opt == trig_seq_pkg::CTRL_OPT_SW_WAIT);
   wire waitable     = (op == trig_seq_pkg::OP_WAIT_HIGH) ||
                       (op == trig_seq_pkg::OP_WAIT_LOW)  || sw_wait_cmd ||
                       (op == trig_seq_pkg::OP_STEP_DELAY) ||
                       (op == trig_seq_pkg::OP_TIMER_WAIT);
   wire wait_met     = (op == trig_seq_pkg::OP_WAIT_HIGH)  ? high_met :
                       (op == trig_seq_pkg::OP_WAIT_LOW)   ? low_met  :
                       (op == trig_seq_pkg::OP_STEP_DELAY) ?
                          (step_delay_counter >= step_delay_limit) :
                       (op == trig_seq_pkg::OP_TIMER_WAIT) ?
                          (timer >= timer_limit) :
                       sw_trigger;
   wire in_wait      = (state == ST_WAIT);
   wire wait_done    = running && in_wait && wait_met;
   wire consume_sw   = wait_done && sw_wait_cmd;
   wire fire         = running && (state == ST_EXEC) &&
                       (op == trig_seq_pkg::OP_TRIG_OUT);
   wire loop_take    = running && (state == ST_EXEC) &&
                       (op == trig_seq_pkg::OP_LOOP_JUMP) &&
                       (loop_counter < loop_counter_limit);
   wire loop_exit    = running && (state == ST_EXEC) &&
                       (op == trig_seq_pkg::OP_LOOP_JUMP) && !loop_take;
   wire step_end     = (running && (state == ST_EXEC) && !waitable) || wait_done;
   wire wdog_expire  = running && in_wait && !wait_met && (wdog_count >= wdog_limit);
   // Software write of zero clears the flag; hardware set wins the tie
   wire wdog_clr     = wr_ctrl && !I_WDATA[trig_seq_pkg::BIT_WDOG_TO];
   wire sw_set       = wr_ctrl && I_WDATA[trig_seq_pkg::BIT_SW_TRIG];

   // Halting holds the current step, so idle stop loses no command
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:  if (may_fetch) next_state = ST_FETCH;
         ST_FETCH: begin
            if (!enabled || !started) next_state = ST_IDLE;
            else if (running) next_state = ST_EXEC;
         end
         ST_EXEC:  begin
            if (!enabled || !started) next_state = ST_IDLE;
            else if (idle_halt) next_state = ST_EXEC;
            else if (waitable) next_state = ST_WAIT;
            else next_state = ST_HOLD;
         end
         ST_WAIT:  begin
            if (!enabled || !started) next_state = ST_IDLE;
            else if (wdog_expire) next_state = ST_IDLE;
            else if (wait_done) next_state = ST_HOLD;
         end
         ST_HOLD:  begin
            if (!enabled || !started) next_state = ST_IDLE;
            else if (may_fetch) next_state = ST_FETCH;
         end
         default:  next_state = ST_IDLE;
      endcase
   end

   // Control/status register; stopping also clears start on time-out
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ctrl <= trig_seq_pkg::CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl[trig_seq_pkg::BIT_ENABLE]     <= I_WDATA[trig_seq_pkg::BIT_ENABLE];
            ctrl[trig_seq_pkg::BIT_IDLE_STOP]  <= I_WDATA[trig_seq_pkg::BIT_IDLE_STOP];
            ctrl[trig_seq_pkg::BIT_TOGGLE]     <= I_WDATA[trig_seq_pkg::BIT_TOGGLE];
            ctrl[trig_seq_pkg::BIT_SSTEP]      <= I_WDATA[trig_seq_pkg::BIT_SSTEP];
            ctrl[trig_seq_pkg::BIT_VISIBLE]    <= I_WDATA[trig_seq_pkg::BIT_VISIBLE];
            ctrl[trig_seq_pkg::BIT_START]      <= I_WDATA[trig_seq_pkg::BIT_START];
            ctrl[trig_seq_pkg::BIT_WAIT_MODE1] <= I_WDATA[trig_seq_pkg::BIT_WAIT_MODE1];
            ctrl[trig_seq_pkg::BIT_WAIT_MODE0] <= I_WDATA[trig_seq_pkg::BIT_WAIT_MODE0];
         end
         if (wdog_expire) begin
            ctrl[trig_seq_pkg::BIT_WDOG_TO] <= 1'b1;
            ctrl[trig_seq_pkg::BIT_START]   <= 1'b0;
         end else if (wdog_clr) begin
            ctrl[trig_seq_pkg::BIT_WDOG_TO] <= 1'b0;
         end
         ctrl[14]  <= 1'b0;
         ctrl[11]  <= 1'b0;
         ctrl[10]  <= 1'b0;
         ctrl[5:2] <= 4'h0;
      end
   end

   // Software trigger pends until a software-wait step takes it
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sw_trigger  <= 1'b0;
         step_permit <= 1'b0;
      end else begin
         sw_trigger  <= sw_set || (sw_trigger && !consume_sw);
         step_permit <= sw_set || (step_permit && !(state == ST_FETCH));
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         step_delay_limit   <= trig_seq_pkg::LIMIT_RESET;
         loop_counter_limit <= trig_seq_pkg::LIMIT_RESET;
         timer_limit        <= trig_seq_pkg::LIMIT_RESET;
         pulse_width_field  <= 4'h0;
         wdog_limit         <= trig_seq_pkg::WDOG_RESET;
      end else begin
         if (wr_sdl)  step_delay_limit   <= I_WDATA;
         if (wr_loop) loop_counter_limit <= I_WDATA;
         if (wr_tmr)  timer_limit        <= I_WDATA;
         if (wr_pw)   pulse_width_field  <= I_WDATA[3:0];
         if (wr_wdog) wdog_limit         <= I_WDATA;
      end
   end

   // Command store; software should load it while the sequencer is stopped
   always_ff @(posedge I_CLK) begin
      if (I_CMD_WR) cmd_mem[I_CMD_ADDR] <= I_CMD_DATA;
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state <= ST_IDLE;
         pc    <= trig_seq_pkg::CMD_ADDR_RESET;
         cmd   <= 8'h00;
      end else begin
         state <= next_state;
         if (!enabled) pc <= trig_seq_pkg::CMD_ADDR_RESET;
         else if (running && state == ST_FETCH) begin
            cmd <= cmd_mem[pc];
            pc  <= pc + 4'h1;
         end else if (loop_take) pc <= opt;
      end
   end

   // Counters run only while the sequencer runs
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         step_delay_counter <= 16'h0000;
         loop_counter       <= 16'h0000;
         timer              <= 16'h0000;
         wdog_count         <= 16'h0000;
         in_prev            <= '0;
      end else begin
         in_prev <= I_TRIG_IN;
         if (running && in_wait) wdog_count <= wdog_count + 16'h0001;
         else if (running) wdog_count <= 16'h0000;
         if (running && in_wait && op == trig_seq_pkg::OP_STEP_DELAY)
            step_delay_counter <= step_delay_counter + 16'h0001;
         else if (running) step_delay_counter <= 16'h0000;
         if (running && in_wait && op == trig_seq_pkg::OP_TIMER_WAIT)
            timer <= timer + 16'h0001;
         else if (running) timer <= 16'h0000;
         if (loop_take) loop_counter <= loop_counter + 16'h0001;
         else if (loop_exit || !enabled) loop_counter <= 16'h0000;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_OUT; g++) begin : g_out
         trig_out_cell #(.PW_BITS(4)) u_cell (
            .i_clk         (I_CLK),
            .i_rst         (I_SYS_RST),
            .i_fire        (fire && (opt[1:0] == 2'(g))),
            .i_toggle_mode (toggle_md),
            .i_pulse_width (pulse_width_field),
            .o_level       (O_TRIG_OUT[g])
         );
      end
   endgenerate

   // Read mux; step delay, loop and timer limit reads switch to live values under visibility
   wire [15:0] sdl_view  = visible ? step_delay_counter : step_delay_limit;
   wire [15:0] loop_view = visible ? loop_counter : loop_counter_limit;
   wire [15:0] tmr_view  = visible ? timer : timer_limit;
   // Unused control bits are held at zero in the register itself
   wire [15:0] rd_mux =
      (I_ADDR == trig_seq_pkg::ADDR_CTRL_STATUS) ? ctrl :
      (I_ADDR == trig_seq_pkg::ADDR_STEP_DELAY)  ? sdl_view :
      (I_ADDR == trig_seq_pkg::ADDR_LOOP_CNT0)   ? loop_view :
      (I_ADDR == trig_seq_pkg::ADDR_TIMER0)      ? tmr_view :
      (I_ADDR == trig_seq_pkg::ADDR_PULSE_WIDTH) ? {12'h000, pulse_width_field} :
      (I_ADDR == trig_seq_pkg::ADDR_WDOG_LIMIT)  ? wdog_limit :
      (I_ADDR == trig_seq_pkg::ADDR_TRIG_LEVEL)  ? {12'h000, O_TRIG_OUT[3:0]} :
      16'h0000;

   // Data outside a read cycle returns to zero
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) rdata <= 16'h0000;
      else if (I_RD) rdata <= rd_mux;
      else rdata <= 16'h0000;
   end

   assign O_RDATA     = rdata;
   assign O_STEP_DONE = step_end;
   assign O_BUSY      = (state != ST_IDLE);
endmodule
`default_nettype wire

// ### trig_seq_properties.sv
/* Port checker of the trigger sequencer control block.
   Assumes one clock and a plain register master with one-cycle strobes. */
`timescale 1ns/10ps
`default_nettype none
module trig_seq_properties (
   input wire logic        I_CLK,
   input wire logic        I_SYS_RST,
   input wire logic [2:0]  I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic        I_WR,
   input wire logic        I_RD,
   input wire logic [15:0] O_RDATA,
   input wire logic        O_STEP_DONE,
   input wire logic        O_BUSY
);
   logic [15:0] ctrl;
   logic [15:0] sdlim;
   logic        rd_q;
   logic        sd_q;
   logic        to_seen;
   logic        ran;
   logic [3:0]  stop_cnt;
   logic [3:0]  off_cnt;
   wire         ctrl_wr = I_WR && I_ADDR == trig_seq_pkg::ADDR_CTRL_STATUS;
   wire         ctrl_rd = I_RD && I_ADDR == trig_seq_pkg::ADDR_CTRL_STATUS;
   // Saturating counts: long quiet spans without a long repetition
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ctrl <= 16'h0000;
         sdlim <= 16'h0000;
         rd_q <= 1'b0;
         sd_q <= 1'b0;
         to_seen <= 1'b0;
         ran <= 1'b0;
         stop_cnt <= 4'h0;
         off_cnt <= 4'h0;
      end else begin
         rd_q <= ctrl_rd;
         sd_q <= I_RD && I_ADDR == trig_seq_pkg::ADDR_STEP_DELAY;
         if (ctrl_wr) begin
            ctrl <= I_WDATA & trig_seq_pkg::CTRL_WR_MASK;
         end
         if (I_WR && I_ADDR == trig_seq_pkg::ADDR_STEP_DELAY) begin
            sdlim <= I_WDATA;
         end
         if (ctrl_wr && !I_WDATA[6]) begin
            to_seen <= 1'b0;
         end else if (rd_q && O_RDATA[6]) begin
            to_seen <= 1'b1;
         end
         if (ctrl_wr && I_WDATA[7]) begin
            ran <= 1'b1;
         end else if (ctrl_wr && I_WDATA[7:6] == 2'b00) begin
            ran <= 1'b0;
         end
         stop_cnt <= ctrl[7] ? 4'h0 : (stop_cnt == 4'hF ? 4'hF : stop_cnt + 4'h1);
         off_cnt <= ctrl[15] ? 4'h0 : (off_cnt == 4'hF ? 4'hF : off_cnt + 4'h1);
      end
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   property p_unused;
      rd_q |-> (O_RDATA & 16'h483C) == 16'h0000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits set");
   property p_swt_zero;
      rd_q |-> !O_RDATA[10];
   endproperty
   a_swt_zero: assert property (p_swt_zero) else $error("sw trigger reads one");
   property p_ctrl_rb;
      rd_q |-> (O_RDATA & 16'hB303) == (ctrl & 16'hB303);
   endproperty
   a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
   property p_sdlim;
      sd_q && !ctrl[8] |-> O_RDATA == sdlim;
   endproperty
   a_sdlim: assert property (p_sdlim) else $error("limit readback wrong");
   property p_to_hold;
      rd_q && to_seen |-> O_RDATA[6];
   endproperty
   a_to_hold: assert property (p_to_hold) else $error("timeout flag lost");
   property p_to_idle;
      rd_q && !ran |-> !O_RDATA[6];
   endproperty
   a_to_idle: assert property (p_to_idle) else $error("timeout flag without run");
   property p_stop;
      stop_cnt == 4'hF |-> !O_STEP_DONE;
   endproperty
   a_stop: assert property (p_stop) else $error("step while stopped");
   property p_off;
      off_cnt == 4'hF |-> !O_BUSY;
   endproperty
   a_off: assert property (p_off) else $error("busy while disabled");
   c_to: cover property (rd_q && O_RDATA[6]);
   c_step: cover property (O_STEP_DONE);
   c_busy: cover property ($rose(O_BUSY));
endmodule
bind trig_seq_ctrl trig_seq_properties u_trig_seq_properties (
   .I_CLK(I_CLK),
   .I_SYS_RST(I_SYS_RST),
   .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA),
   .I_WR(I_WR),
   .I_RD(I_RD),
   .O_RDATA(O_RDATA),
   .O_STEP_DONE(O_STEP_DONE),
   .O_BUSY(O_BUSY)
);
`default_nettype wire

// ### trig_sink.sv
/* Peripheral side of the trigger outputs: counts level changes of
   output 0, measures its last high run and echoes levels back as inputs.
   Assumes the trigger outputs are registered in the same clock domain. */
`timescale 1ns/10ps
`default_nettype none
module trig_sink (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [3:0] i_trig,
   output logic      [3:0] o_echo,
   output int              o_edges,
   output int              o_high_len
);
   logic prev;
   int   run;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev <= 1'b0;
         run <= 0;
         o_edges <= 0;
         o_high_len <= 0;
         o_echo <= 4'h0;
      end else begin
         prev <= i_trig[0];
         o_echo <= i_trig;
         run <= i_trig[0] ? run + 1 : 0;
         if (i_trig[0] !== prev) begin
            o_edges <= o_edges + 1;
         end
         if (prev && !i_trig[0]) begin
            o_high_len <= run;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb.sv
/* Self-checking bench of the trigger sequencer control block.
   Assumes the checker is bound in and the sink model sits on the outputs. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        cwr = 1'b0;
   logic [3:0]  caddr = 4'h0;
   logic [7:0]  cdata = 8'h00;
   logic        idle = 1'b0;
   logic [3:0]  tin;
   logic [15:0] rdata;
   logic [3:0]  tout;
   logic        sdone;
   logic        busy;
   logic [15:0] q;
   int          edges;
   int          hlen;
   int          e0;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   always #4 clk = ~clk;
   trig_seq_ctrl u_trig_seq_ctrl (.I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_CMD_WR(cwr), .I_CMD_ADDR(caddr),
      .I_CMD_DATA(cdata), .I_DEVICE_IDLE(idle), .I_TRIG_IN(tin), .O_RDATA(rdata),
      .O_TRIG_OUT(tout), .O_STEP_DONE(sdone), .O_BUSY(busy));
   trig_sink u_trig_sink (.i_clk(clk), .i_rst(rst), .i_trig(tout), .o_echo(tin),
      .o_edges(edges), .o_high_len(hlen));
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Generous ceiling, the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         conclude;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata;
   endtask
   task automatic ld(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      caddr <= a;
      cdata <= d;
      cwr <= 1'b1;
      @(posedge clk);
      cwr <= 1'b0;
   endtask
   task automatic wr_wait(input logic [15:0] d);
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, d);
      repeat (20) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      rd_reg(trig_seq_pkg::ADDR_CTRL_STATUS);
      chk(q, trig_seq_pkg::CTRL_RESET);
      rd_reg(trig_seq_pkg::ADDR_WDOG_LIMIT);
      chk(q, trig_seq_pkg::WDOG_RESET);
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'hFBFF);
      rd_reg(trig_seq_pkg::ADDR_CTRL_STATUS);
      chk(q, 16'hB383);
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h0000);
      $display("test reset and mask done");
   endtask
   task automatic t_vis;
      wr_reg(trig_seq_pkg::ADDR_STEP_DELAY, 16'h0005);
      rd_reg(trig_seq_pkg::ADDR_STEP_DELAY);
      chk(q, 16'h0005);
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h8100);
      rd_reg(trig_seq_pkg::ADDR_STEP_DELAY);
      chk(q, 16'h0000);
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h0000);
      $display("test visibility done");
   endtask
   // Program: wait on software trigger, fire output 0, loop back
   task automatic t_seq;
      ld(4'h0, 8'h0A);
      ld(4'h1, 8'h30);
      for (int i = 2; i < 16; i++) begin
         ld(4'(i), 8'h60);
      end
      wr_reg(trig_seq_pkg::ADDR_LOOP_CNT0, 16'h00FF);
      e0 = edges;
      wr_wait(16'h9080);
      wr_wait(16'h9080);
      chk(16'(edges - e0), 16'h0000);
      wr_wait(16'h9480);
      chk(16'(edges - e0), 16'h0001);
      chk({15'h0000, tout[0]}, 16'h0001);
      wr_wait(16'h9483);
      chk(16'(edges - e0), 16'h0002);
      wr_reg(trig_seq_pkg::ADDR_PULSE_WIDTH, 16'h0002);
      wr_wait(16'h8480);
      chk(16'(edges - e0), 16'h0004);
      chk(16'(hlen), 16'h0003);
      $display("test sequence done");
   endtask
   task automatic t_idle;
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'hB080);
      idle <= 1'b1;
      e0 = edges;
      wr_wait(16'hB480);
      chk(16'(edges - e0), 16'h0000);
      @(posedge clk);
      idle <= 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk(16'(edges - e0), 16'h0001);
      $display("test idle stop done");
   endtask
   task automatic t_stop;
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h9000);
      e0 = edges;
      wr_wait(16'h9400);
      chk(16'(edges - e0), 16'h0000);
      wr_wait(16'h0000);
      chk({15'h0000, busy}, 16'h0000);
      $display("test stop done");
   endtask
   task automatic t_wdog;
      wr_reg(trig_seq_pkg::ADDR_WDOG_LIMIT, 16'h0010);
      wr_wait(16'h8080);
      repeat (40) @(posedge clk);
      rd_reg(trig_seq_pkg::ADDR_CTRL_STATUS);
      chk(q & 16'h00C0, 16'h0040);
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h8040);
      rd_reg(trig_seq_pkg::ADDR_CTRL_STATUS);
      chk(q & 16'h0040, 16'h0040);
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h8000);
      rd_reg(trig_seq_pkg::ADDR_CTRL_STATUS);
      chk(q & 16'h0040, 16'h0000);
      $display("test watchdog done");
   endtask
   task automatic t_sstep;
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h0000);
      e0 = edges;
      wr_wait(16'h9280);
      chk({15'h0000, busy}, 16'h0000);
      wr_wait(16'h9680);
      chk(16'(edges - e0), 16'h0000);
      chk({15'h0000, busy}, 16'h0001);
      wr_wait(16'h9680);
      chk(16'(edges - e0), 16'h0001);
      $display("test single step done");
   endtask
   // Output 1 echoes back as input 1; edge mode misses the level
   task automatic t_wait;
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h1000);
      ld(4'h0, 8'h31);
      ld(4'h1, 8'h11);
      ld(4'h2, 8'h30);
      ld(4'h3, 8'h21);
      e0 = edges;
      wr_wait(16'h9082);
      chk(16'(edges - e0), 16'h0000);
      wr_reg(trig_seq_pkg::ADDR_CTRL_STATUS, 16'h1000);
      ld(4'h0, 8'h00);
      wr_wait(16'h9080);
      chk(16'(edges - e0), 16'h0001);
      $display("test wait mode done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_vis;
      t_seq;
      t_idle;
      t_stop;
      t_wdog;
      t_sstep;
      t_wait;
      conclude;
   end
endmodule
`default_nettype wire
